/* design/pmec_pkg.sv */
// constants, types and register map of the power-mode and event control block
// assumes a 100 MHz core clock and a 10-bit word-addressed register port
package pmec_pkg;

    typedef enum logic [1:0] {PMEC_IDLE, PMEC_DETECT, PMEC_PARTIAL, PMEC_NORMAL} pmec_mode_type;

    localparam logic [1:0] MODE_CODE_NORMAL = 2'h3;
    localparam logic [1:0] MODE_CODE_PARTIAL = 2'h2;
    localparam logic [1:0] MODE_CODE_DETECT = 2'h1;
    localparam logic [1:0] MODE_CODE_IDLE = 2'h0;
    localparam int MODE_STABLE_CYCLES = 4;

    localparam int CLK_HZ = 100000000;
    localparam int SAMPLE_RATE_HZ = 8000;
    localparam int SAG_WINDOW_US = 11000;
    localparam int SAG_WINDOW_SAMPLES = SAG_WINDOW_US * (SAMPLE_RATE_HZ / 1000) / 1000;
    localparam int SAG_MIN_HITS = 3;

    localparam logic [9:0] ADDR_SOFT_RESET = 10'h000;
    localparam logic [9:0] ADDR_STATUS0 = 10'h001;
    localparam logic [9:0] ADDR_ENABLE0 = 10'h003;
    localparam logic [9:0] ADDR_ZX_CONFIG = 10'h007;
    localparam logic [9:0] ADDR_CMP_CTRL = 10'h00e;
    localparam logic [9:0] ADDR_SPECIAL_F = 10'h00f;
    localparam logic [9:0] ADDR_SAG_TH = 10'h010;
    localparam logic [9:0] ADDR_LOSS_TH = 10'h011;
    localparam logic [9:0] ADDR_EVENT_STATE = 10'h012;
    localparam logic [9:0] ADDR_PM_FIRST = 10'h014;
    localparam logic [9:0] ADDR_PM_LAST = 10'h01d;

    localparam int STAT_LOSS_BIT = 1;
    localparam int STAT_SAG_BIT = 3;

    localparam logic [15:0] ENABLE0_RST = 16'h0000;
    localparam logic [15:0] ZX_CONFIG_RST = 16'h0000;
    localparam logic [15:0] CMP_CTRL_RST = 16'h003f;
    localparam logic [15:0] SAG_TH_RST = 16'h1000;
    localparam logic [15:0] LOSS_TH_RST = 16'h0200;

    typedef struct packed {
        logic [9:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } pmec_bus_req_type;

    typedef struct packed {
        logic valid;
        logic [2:0][15:0] mag;
    } pmec_sample_type;

    typedef struct packed {
        logic [2:0] volt;
        logic [2:0] curr;
    } pmec_zx_raw_type;

    typedef struct packed {
        logic [3:0] energy_pulse;
        logic warning;
        logic serial_data_out;
        logic sdo_drive;
    } pmec_core_out_type;

endpackage : pmec_pkg

/* design/pmec_top.sv */
// power-mode decode, mode sequencing, detection interrupts and voltage event logic
// assumes samples, zero-cross and metering signals come from logic on clk_i;
// mode pins and comparator outputs are asynchronous and get synchronised here
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/100ps
module pmec_top #(
    parameter int STABLE_CYCLES = pmec_pkg::MODE_STABLE_CYCLES
) (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire logic mode_select_hi_i,
    input wire logic mode_select_lo_i,
    input wire logic [2:0] cmp_pos_over_i,
    input wire logic [2:0] cmp_neg_over_i,
    input wire logic pm_done_i,
    input wire pmec_pkg::pmec_sample_type sample_i,
    input wire pmec_pkg::pmec_zx_raw_type zx_raw_i,
    input wire pmec_pkg::pmec_core_out_type core_out_i,
    input wire pmec_pkg::pmec_bus_req_type bus_i,
    output logic [15:0] rdata_o,
    output logic first_interrupt_out_o,
    output logic second_interrupt_out_o,
    output logic zero_cross_out_a_o,
    output logic zero_cross_out_b_o,
    output logic zero_cross_out_c_o,
    output logic energy_pulse_out_1_o,
    output logic energy_pulse_out_2_o,
    output logic energy_pulse_out_3_o,
    output logic energy_pulse_out_4_o,
    output logic warning_out_o,
    output logic serial_data_out_o,
    output logic serial_data_out_oe_n_o,
    output logic oscillator_out_en_o,
    output logic core_regulator_supply_en_o,
    output logic core_por_o,
    output logic lp_detector_en_o,
    output logic [5:0] cmp_power_o,
    output logic voltage_adc_en_o,
    output logic pm_meas_en_o,
    output logic [1:0] freq_phase_sel_o
);

    localparam logic [2:0] STABLE_LAST = 3'(STABLE_CYCLES - 1);
    localparam logic [6:0] WIN_LAST = 7'(pmec_pkg::SAG_WINDOW_SAMPLES - 1);
    localparam logic [1:0] MIN_HITS = 2'(pmec_pkg::SAG_MIN_HITS);

    function automatic pmec_pkg::pmec_mode_type mode_decode(input logic [1:0] code);
        pmec_pkg::pmec_mode_type m;
        unique case (code)
            pmec_pkg::MODE_CODE_NORMAL: m = pmec_pkg::PMEC_NORMAL;
            pmec_pkg::MODE_CODE_PARTIAL: m = pmec_pkg::PMEC_PARTIAL;
            pmec_pkg::MODE_CODE_DETECT: m = pmec_pkg::PMEC_DETECT;
            pmec_pkg::MODE_CODE_IDLE: m = pmec_pkg::PMEC_IDLE;
        endcase
        return m;
    endfunction : mode_decode

    function automatic logic partial_allowed(input logic [9:0] a);
        return (a >= pmec_pkg::ADDR_PM_FIRST && a <= pmec_pkg::ADDR_PM_LAST)
            || a == pmec_pkg::ADDR_SOFT_RESET || a == pmec_pkg::ADDR_STATUS0
            || a == pmec_pkg::ADDR_ENABLE0 || a == pmec_pkg::ADDR_ZX_CONFIG
            || a == pmec_pkg::ADDR_CMP_CTRL || a == pmec_pkg::ADDR_SPECIAL_F;
    endfunction : partial_allowed

    function automatic logic [1:0] hit_count(input logic [1:0] cnt, input logic hit);
        return (hit && cnt != 2'h3) ? cnt + 2'h1 : cnt;
    endfunction : hit_count

    function automatic logic core_on(input pmec_pkg::pmec_mode_type m);
        return m == pmec_pkg::PMEC_PARTIAL || m == pmec_pkg::PMEC_NORMAL;
    endfunction : core_on

    // mode pins: two-stage synchroniser plus stability filter
    logic [1:0] pin_meta_q;
    logic [1:0] pin_sync_q;
    logic [1:0] code_last_q, code_last_d;
    logic [2:0] stable_cnt_q, stable_cnt_d;
    pmec_pkg::pmec_mode_type mode_q, mode_d;
    logic mode_chg;
    logic por_q, por_d;
    logic soft_rst_q, soft_rst_d;
    logic core_clr;

    always_comb
    begin
        code_last_d = pin_sync_q;
        stable_cnt_d = 3'h0;
        mode_d = mode_q;
        if (pin_sync_q == code_last_q)
        begin
            stable_cnt_d = (stable_cnt_q == STABLE_LAST) ? stable_cnt_q : stable_cnt_q + 3'h1;
            if (stable_cnt_q == STABLE_LAST)
                mode_d = mode_decode(code_last_q);
        end
        mode_chg = mode_d != mode_q;
        // regulator turning on means the core comes up from cold
        por_d = mode_chg && core_on(mode_d) && !core_on(mode_q);
        soft_rst_d = bus_i.wr && bus_i.addr == pmec_pkg::ADDR_SOFT_RESET
            && mode_q == pmec_pkg::PMEC_NORMAL;
    end

    always_ff @(posedge clk_i)
    begin
        pin_meta_q <= {mode_select_hi_i, mode_select_lo_i};
        pin_sync_q <= pin_meta_q;
        if (srst_i)
        begin
            code_last_q <= pmec_pkg::MODE_CODE_IDLE;
            stable_cnt_q <= 3'h0;
            mode_q <= pmec_pkg::PMEC_IDLE;
            por_q <= 1'b0;
            soft_rst_q <= 1'b0;
        end
        else
        begin
            code_last_q <= code_last_d;
            stable_cnt_q <= stable_cnt_d;
            mode_q <= mode_d;
            por_q <= por_d;
            soft_rst_q <= soft_rst_d;
        end
    end

    assign core_clr = srst_i || por_q || soft_rst_q;
    assign core_por_o = por_q;

    // per-mode power enables, decoded straight from the settled mode
    assign core_regulator_supply_en_o = core_on(mode_q);
    assign lp_detector_en_o = mode_q == pmec_pkg::PMEC_DETECT;
    assign voltage_adc_en_o = mode_q == pmec_pkg::PMEC_NORMAL;
    assign pm_meas_en_o = core_on(mode_q);
    assign oscillator_out_en_o = mode_q != pmec_pkg::PMEC_IDLE;

    // configuration registers survive the cold core start
    logic [15:0] enable0_q, enable0_d;
    logic [15:0] zx_cfg_q, zx_cfg_d;
    logic [15:0] cmp_ctrl_q, cmp_ctrl_d;
    logic [15:0] sag_th_q, sag_th_d;
    logic [15:0] loss_th_q, loss_th_d;
    logic [15:0] status_q, status_d;
    logic [15:0] rdata_q, rdata_d;
    logic access_ok;
    logic sag_rise, loss_rise;

    always_comb
    begin
        access_ok = mode_q == pmec_pkg::PMEC_NORMAL
            || (mode_q == pmec_pkg::PMEC_PARTIAL && partial_allowed(bus_i.addr));
        enable0_d = enable0_q;
        zx_cfg_d = zx_cfg_q;
        cmp_ctrl_d = cmp_ctrl_q;
        sag_th_d = sag_th_q;
        loss_th_d = loss_th_q;
        if (bus_i.wr && access_ok)
        begin
            unique case (bus_i.addr)
                pmec_pkg::ADDR_ENABLE0: enable0_d = bus_i.wdata;
                pmec_pkg::ADDR_ZX_CONFIG: zx_cfg_d = bus_i.wdata;
                pmec_pkg::ADDR_CMP_CTRL: cmp_ctrl_d = bus_i.wdata;
                pmec_pkg::ADDR_SAG_TH: sag_th_d = bus_i.wdata;
                pmec_pkg::ADDR_LOSS_TH: loss_th_d = bus_i.wdata;
                default: ;
            endcase
        end
        rdata_d = 16'h0000;
        if (bus_i.rd && access_ok)
        begin
            unique case (bus_i.addr)
                pmec_pkg::ADDR_STATUS0: rdata_d = status_q;
                pmec_pkg::ADDR_ENABLE0: rdata_d = enable0_q;
                pmec_pkg::ADDR_ZX_CONFIG: rdata_d = zx_cfg_q;
                pmec_pkg::ADDR_CMP_CTRL: rdata_d = cmp_ctrl_q;
                pmec_pkg::ADDR_SAG_TH: rdata_d = sag_th_q;
                pmec_pkg::ADDR_LOSS_TH: rdata_d = loss_th_q;
                pmec_pkg::ADDR_EVENT_STATE: rdata_d = event_state();
                default: rdata_d = 16'h0000;
            endcase
        end
        // read clears, but an event in the same cycle still lands
        status_d = status_q;
        if (bus_i.rd && access_ok && bus_i.addr == pmec_pkg::ADDR_STATUS0)
            status_d = 16'h0000;
        status_d[pmec_pkg::STAT_SAG_BIT] = status_d[pmec_pkg::STAT_SAG_BIT] | sag_rise;
        status_d[pmec_pkg::STAT_LOSS_BIT] = status_d[pmec_pkg::STAT_LOSS_BIT] | loss_rise;
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            enable0_q <= pmec_pkg::ENABLE0_RST;
            zx_cfg_q <= pmec_pkg::ZX_CONFIG_RST;
            cmp_ctrl_q <= pmec_pkg::CMP_CTRL_RST;
            sag_th_q <= pmec_pkg::SAG_TH_RST;
            loss_th_q <= pmec_pkg::LOSS_TH_RST;
            rdata_q <= 16'h0000;
        end
        else
        begin
            enable0_q <= enable0_d;
            zx_cfg_q <= zx_cfg_d;
            cmp_ctrl_q <= cmp_ctrl_d;
            sag_th_q <= sag_th_d;
            loss_th_q <= loss_th_d;
            rdata_q <= rdata_d;
        end
        if (core_clr)
            status_q <= 16'h0000;
        else
            status_q <= status_d;
    end

    assign rdata_o = rdata_q;

    // sag and phase-loss windows, only while voltage converters run
    logic [6:0] win_cnt_q, win_cnt_d;
    logic [2:0][1:0] sag_hits_q, sag_hits_d, loss_hits_q, loss_hits_d;
    logic [2:0] sag_low_q, sag_low_d, loss_low_q, loss_low_d;
    logic [2:0] sag_q, sag_d, loss_q, loss_d;
    logic [1:0] freq_sel_q, freq_sel_d;

    function automatic logic [15:0] event_state();
        return {4'h0, freq_sel_q, 1'b0, loss_q, sag_q, 1'b0, mode_q};
    endfunction : event_state

    always_comb
    begin
        win_cnt_d = win_cnt_q;
        sag_hits_d = sag_hits_q;
        loss_hits_d = loss_hits_q;
        sag_low_d = sag_low_q;
        loss_low_d = loss_low_q;
        sag_d = sag_q;
        loss_d = loss_q;
        if (mode_q == pmec_pkg::PMEC_NORMAL && sample_i.valid)
        begin
            win_cnt_d = (win_cnt_q == WIN_LAST) ? 7'h00 : win_cnt_q + 7'h01;
            for (int p = 0; p < 3; p++)
            begin
                sag_hits_d[p] = hit_count(sag_hits_q[p], sample_i.mag[p] > sag_th_q);
                loss_hits_d[p] = hit_count(loss_hits_q[p], sample_i.mag[p] > loss_th_q);
                if (win_cnt_q == WIN_LAST)
                begin
                    sag_low_d[p] = sag_hits_d[p] < MIN_HITS;
                    loss_low_d[p] = loss_hits_d[p] < MIN_HITS;
                    sag_d[p] = sag_low_q[p] && sag_low_d[p];
                    loss_d[p] = loss_low_q[p] && loss_low_d[p];
                    sag_hits_d[p] = 2'h0;
                    loss_hits_d[p] = 2'h0;
                end
            end
        end
        sag_rise = |(sag_d & ~sag_q);
        loss_rise = |(loss_d & ~loss_q);
        // frequency source falls back a -> c -> b as sags appear
        if (!sag_q[0])
            freq_sel_d = 2'h0;
        else if (!sag_q[2])
            freq_sel_d = 2'h2;
        else
            freq_sel_d = 2'h1;
    end

    always_ff @(posedge clk_i)
    begin
        if (core_clr || mode_q != pmec_pkg::PMEC_NORMAL)
        begin
            win_cnt_q <= 7'h00;
            sag_hits_q <= '0;
            loss_hits_q <= '0;
            sag_low_q <= 3'h0;
            loss_low_q <= 3'h0;
            sag_q <= 3'h0;
            loss_q <= 3'h0;
            freq_sel_q <= 2'h0;
        end
        else
        begin
            win_cnt_q <= win_cnt_d;
            sag_hits_q <= sag_hits_d;
            loss_hits_q <= loss_hits_d;
            sag_low_q <= sag_low_d;
            loss_low_q <= loss_low_d;
            sag_q <= sag_d;
            loss_q <= loss_d;
            freq_sel_q <= freq_sel_d;
        end
    end

    assign freq_phase_sel_o = freq_sel_q;

    // detection comparators cross in from the analog side
    logic [5:0] cmp_meta_q, cmp_sync_q;
    logic [2:0] phase_over;
    logic det_first_interrupt_out_q, det_first_interrupt_out_d, det_second_interrupt_out_q, det_second_interrupt_out_d;
    logic pm_irq_q, pm_irq_d;

    assign cmp_power_o = (mode_q == pmec_pkg::PMEC_DETECT) ? cmp_ctrl_q[5:0] : 6'h00;

    always_comb
    begin
        phase_over = (cmp_sync_q[2:0] & cmp_ctrl_q[2:0]) | (cmp_sync_q[5:3] & cmp_ctrl_q[5:3]);
        det_first_interrupt_out_d = det_first_interrupt_out_q;
        det_second_interrupt_out_d = det_second_interrupt_out_q;
        pm_irq_d = pm_irq_q;
        if (mode_chg)
        begin
            det_first_interrupt_out_d = 1'b0;
            det_second_interrupt_out_d = 1'b0;
            pm_irq_d = 1'b0;
        end
        else if (mode_q == pmec_pkg::PMEC_DETECT)
        begin
            det_first_interrupt_out_d = det_first_interrupt_out_q || (|phase_over);
            det_second_interrupt_out_d = det_second_interrupt_out_q || (&phase_over);
        end
        else if (mode_q == pmec_pkg::PMEC_PARTIAL)
            pm_irq_d = pm_irq_q || pm_done_i;
    end

    always_ff @(posedge clk_i)
    begin
        cmp_meta_q <= {cmp_neg_over_i, cmp_pos_over_i};
        cmp_sync_q <= cmp_meta_q;
        if (srst_i)
        begin
            det_first_interrupt_out_q <= 1'b0;
            det_second_interrupt_out_q <= 1'b0;
            pm_irq_q <= 1'b0;
        end
        else
        begin
            det_first_interrupt_out_q <= det_first_interrupt_out_d;
            det_second_interrupt_out_q <= det_second_interrupt_out_d;
            pm_irq_q <= pm_irq_d;
        end
    end

    // pin outputs, forced quiet in idle; detect drives only the two interrupt pins
    logic first_interrupt_out_q, first_interrupt_out_d, second_interrupt_out_q, second_interrupt_out_d;
    logic [2:0] zx_q, zx_d;
    logic [3:0] cf_q, cf_d;
    logic warn_q, warn_d, sdo_q, sdo_d, sdo_oe_n_q, sdo_oe_n_d;

    always_comb
    begin
        first_interrupt_out_d = 1'b0;
        second_interrupt_out_d = 1'b0;
        zx_d = 3'h0;
        cf_d = 4'h0;
        warn_d = 1'b0;
        sdo_d = 1'b0;
        sdo_oe_n_d = 1'b1;
        unique case (mode_q)
            pmec_pkg::PMEC_IDLE: ;
            pmec_pkg::PMEC_DETECT:
            begin
                first_interrupt_out_d = det_first_interrupt_out_q;
                second_interrupt_out_d = det_second_interrupt_out_q;
            end
            pmec_pkg::PMEC_PARTIAL:
            begin
                first_interrupt_out_d = pm_irq_q;
                sdo_d = core_out_i.serial_data_out;
                sdo_oe_n_d = !core_out_i.sdo_drive;
            end
            pmec_pkg::PMEC_NORMAL:
            begin
                first_interrupt_out_d = |(status_q & enable0_q);
                for (int p = 0; p < 3; p++)
                    zx_d[p] = zx_cfg_q[p + 3] && !loss_q[p]
                        && (zx_cfg_q[p] ? zx_raw_i.curr[p] : zx_raw_i.volt[p]);
                cf_d = core_out_i.energy_pulse;
                warn_d = core_out_i.warning;
                sdo_d = core_out_i.serial_data_out;
                sdo_oe_n_d = !core_out_i.sdo_drive;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            first_interrupt_out_q <= 1'b0;
            second_interrupt_out_q <= 1'b0;
            zx_q <= 3'h0;
            cf_q <= 4'h0;
            warn_q <= 1'b0;
            sdo_q <= 1'b0;
            sdo_oe_n_q <= 1'b1;
        end
        else
        begin
            first_interrupt_out_q <= first_interrupt_out_d;
            second_interrupt_out_q <= second_interrupt_out_d;
            zx_q <= zx_d;
            cf_q <= cf_d;
            warn_q <= warn_d;
            sdo_q <= sdo_d;
            sdo_oe_n_q <= sdo_oe_n_d;
        end
    end

    assign first_interrupt_out_o = first_interrupt_out_q;
    assign second_interrupt_out_o = second_interrupt_out_q;
    assign zero_cross_out_a_o = zx_q[0];
    assign zero_cross_out_b_o = zx_q[1];
    assign zero_cross_out_c_o = zx_q[2];
    assign {energy_pulse_out_4_o, energy_pulse_out_3_o} = cf_q[3:2];
    assign {energy_pulse_out_2_o, energy_pulse_out_1_o} = cf_q[1:0];
    assign warning_out_o = warn_q;
    assign serial_data_out_o = sdo_q;
    assign serial_data_out_oe_n_o = sdo_oe_n_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    sequence s_cold_mode;
        mode_q == pmec_pkg::PMEC_IDLE || mode_q == pmec_pkg::PMEC_DETECT;
    endsequence
    sequence s_enter_core;
        s_cold_mode ##1 core_on(mode_q);
    endsequence

    AST_POR_ON_ENTRY: assert property (s_enter_core |-> core_por_o)
        else $error("no core reset on regulator turn-on");
    AST_IDLE_QUIET: assert property ((mode_q == pmec_pkg::PMEC_IDLE)[*2] |->
        !first_interrupt_out_q && !second_interrupt_out_q && zx_q == 3'h0 && cf_q == 4'h0 && !warn_q && sdo_oe_n_q)
        else $error("outputs not quiet in idle");
    AST_DET_ANY: assert property (mode_q == pmec_pkg::PMEC_DETECT && !mode_chg
        && |phase_over |=> ##1 first_interrupt_out_o)
        else $error("first interrupt missing on detection");
    AST_DET_ALL: assert property (mode_q == pmec_pkg::PMEC_DETECT && !mode_chg
        && &phase_over |=> ##1 second_interrupt_out_o)
        else $error("second interrupt missing on detection");
    AST_DET_CLEAR: assert property (mode_chg |=> !det_first_interrupt_out_q && !det_second_interrupt_out_q)
        else $error("detection latch not cleared on mode change");
    AST_PM_DONE: assert property (mode_q == pmec_pkg::PMEC_PARTIAL && !mode_chg
        && pm_done_i |=> ##1 first_interrupt_out_o)
        else $error("partial completion interrupt missing");
    AST_PM_ACCESS: assert property (bus_i.rd && mode_q == pmec_pkg::PMEC_PARTIAL
        && !partial_allowed(bus_i.addr) |=> rdata_o == 16'h0000)
        else $error("blocked register readable in partial mode");
    AST_MODE_FILTER: assert property (mode_q != $past(mode_q) |->
        $past(stable_cnt_q) == STABLE_LAST)
        else $error("mode changed before pins settled");
    AST_ZX_LOSS: assert property (loss_q[0] && $past(loss_q[0]) |=> !zero_cross_out_a_o)
        else $error("zero-cross active on lost phase");
    AST_NORMAL_NO_DET: assert property (mode_q == pmec_pkg::PMEC_NORMAL |->
        !lp_detector_en_o && voltage_adc_en_o && cmp_power_o == 6'h00)
        else $error("detector powered in normal mode");
    AST_FREQ_SEL: assert property (sag_q[0] && sag_q[2] && !core_clr
        && mode_q == pmec_pkg::PMEC_NORMAL |=> freq_phase_sel_o == 2'h1)
        else $error("frequency source wrong with a and c sagged");
    AST_SAG_FLAG: assert property (sag_rise && !core_clr |=> status_q[3])
        else $error("sag event not latched");

endmodule : pmec_top

/* verification/pmec_host_model.sv */
// host controller model that drives the two mode pins
// assumes the bench names the wanted mode; the model inserts the idle stop itself
`timescale 1ns/100ps
module pmec_host_model #(
    parameter int DWELL = 12
) (
    input wire logic clk_i,
    input wire logic [1:0] want_i,
    output logic mode_select_hi_o,
    output logic mode_select_lo_o
);
    logic [1:0] cur_q = 2'h0;
    int cnt_q = 0;
    assign mode_select_hi_o = cur_q[1];
    assign mode_select_lo_o = cur_q[0];
    // never jumps between two active modes; idle dwell lets the filter settle
    always @(posedge clk_i)
    begin
        if (cur_q != want_i && cur_q != 2'h0 && want_i != 2'h0)
        begin
            cur_q <= 2'h0;
            cnt_q <= DWELL;
        end
        else if (cur_q != want_i && cnt_q == 0)
            cur_q <= want_i;
        else if (cnt_q != 0)
            cnt_q <= cnt_q - 1;
    end
endmodule : pmec_host_model

/* verification/tb_power_mode_event_control.sv */
// bench for the power-mode and event control block
// assumes one 100 MHz clock; the host model owns the mode pins
`timescale 1ns/100ps
module tb_power_mode_event_control;
    logic clk = 1'b0, srst = 1'b1, pm_done = 1'b0, hi, lo;
    logic [1:0] want = 2'h0;
    logic [2:0] cpos = 3'h0, cneg = 3'h0;
    pmec_pkg::pmec_sample_type smp = '0;
    pmec_pkg::pmec_zx_raw_type zx = '0;
    pmec_pkg::pmec_bus_req_type bus = '0;
    // metering core shows all ones so that idle forcing is visible on the energy pulse, warning and serial pins
    pmec_pkg::pmec_core_out_type core = '1;
    logic [15:0] rdata;
    logic first_interrupt_out, second_interrupt_out, zxa, zxb, zxc, ep1, ep2, ep3, ep4, warn, serial_data_out, sdo_oe_n, osc, reg_en, por;
    logic lp_en, adc_en, pm_en;
    logic [5:0] cmp_pwr;
    logic [1:0] fsel;
    int err_count = 0, checked = 0, por_n = 0;
    initial forever #5 clk = ~clk;
    pmec_host_model pmec_host_model_i (.clk_i(clk), .want_i(want), .mode_select_hi_o(hi),
        .mode_select_lo_o(lo));
    pmec_top #(.STABLE_CYCLES(2)) pmec_top_i (.clk_i(clk), .srst_i(srst),
        .mode_select_hi_i(hi), .mode_select_lo_i(lo), .cmp_pos_over_i(cpos),
        .cmp_neg_over_i(cneg), .pm_done_i(pm_done), .sample_i(smp), .zx_raw_i(zx),
        .core_out_i(core), .bus_i(bus), .rdata_o(rdata), .first_interrupt_out_o(first_interrupt_out),
        .second_interrupt_out_o(second_interrupt_out), .zero_cross_out_a_o(zxa), .zero_cross_out_b_o(zxb),
        .zero_cross_out_c_o(zxc), .energy_pulse_out_1_o(ep1), .energy_pulse_out_2_o(ep2),
        .energy_pulse_out_3_o(ep3), .energy_pulse_out_4_o(ep4), .warning_out_o(warn),
        .serial_data_out_o(serial_data_out), .serial_data_out_oe_n_o(sdo_oe_n),
        .oscillator_out_en_o(osc), .core_regulator_supply_en_o(reg_en), .core_por_o(por),
        .lp_detector_en_o(lp_en), .cmp_power_o(cmp_pwr), .voltage_adc_en_o(adc_en),
        .pm_meas_en_o(pm_en), .freq_phase_sel_o(fsel));
    always @(posedge clk) if (por === 1'b1) por_n++;
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [9:0] a, input logic [15:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [9:0] a, input logic [15:0] exp);
        @(posedge clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 chk("rdata", rdata, exp);
    endtask : rd
    task automatic go(input logic [1:0] m);
        want <= m;
        repeat (45) @(posedge clk);
        #1;
    endtask : go
    // output pins that idle forces low, the regulator and oscillator enables, plus the serial line released
    task automatic idle_pins();
        chk("idle pins", {zxa, zxb, zxc, ep1, ep2, ep3, ep4, warn, serial_data_out, first_interrupt_out, second_interrupt_out, reg_en, osc}, '0);
        chk("sdo oe_n", sdo_oe_n, 16'h0001);
    endtask : idle_pins
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : conclude
    initial
    begin
        #200000 err_count++;
        conclude();
    end
    initial
    begin
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        repeat (3) @(posedge clk);
        #1 idle_pins();
        go(pmec_pkg::MODE_CODE_NORMAL);
        chk("normal en", {osc, reg_en, adc_en, lp_en}, 16'h000e);
        chk("core pins", {ep4, ep3, ep2, ep1, warn, serial_data_out, sdo_oe_n}, 16'h007e);
        chk("por count", por_n, 16'h0001);
        rd(pmec_pkg::ADDR_CMP_CTRL, pmec_pkg::CMP_CTRL_RST);
        rd(10'h3ff, 16'h0000);
        wr(pmec_pkg::ADDR_ENABLE0, 16'h0008);
        wr(pmec_pkg::ADDR_ZX_CONFIG, 16'h0038);
        rd(pmec_pkg::ADDR_ENABLE0, 16'h0008);
        // threshold near 78 percent of a 1000h reference
        wr(pmec_pkg::ADDR_SAG_TH, 16'h0c7b);
        @(posedge clk) zx <= '{volt: 3'h7, curr: 3'h0};
        repeat (3) @(posedge clk);
        #1 chk("zx on", {zxa, zxb, zxc}, 16'h0007);
        chk("freq sel a", fsel, 16'h0000);
        // all phases near zero: sag and loss on every phase after two windows
        repeat (2 * pmec_pkg::SAG_WINDOW_SAMPLES + 4)
        begin
            @(posedge clk) smp <= '{valid: 1'b1, mag: '0};
            @(posedge clk) smp.valid <= 1'b0;
        end
        repeat (4) @(posedge clk);
        #1 chk("sag irq", first_interrupt_out, 16'h0001);
        chk("zx lost", {zxa, zxb, zxc}, 16'h0000);
        chk("freq sel b", fsel, 16'h0001);
        rd(pmec_pkg::ADDR_STATUS0, 16'h000a);
        wr(pmec_pkg::ADDR_CMP_CTRL, 16'h003f);
        go(pmec_pkg::MODE_CODE_IDLE);
        idle_pins();
        go(pmec_pkg::MODE_CODE_DETECT);
        chk("detect pwr", cmp_pwr, 16'h003f);
        chk("detect first_interrupt_out", first_interrupt_out, 16'h0000);
        @(posedge clk) cpos <= 3'h2;
        repeat (6) @(posedge clk);
        #1 chk("one phase", {first_interrupt_out, second_interrupt_out}, 16'h0002);
        @(posedge clk) cneg <= 3'h5;
        repeat (6) @(posedge clk);
        #1 chk("all phases", {first_interrupt_out, second_interrupt_out}, 16'h0003);
        @(posedge clk);
        cpos <= 3'h0;
        cneg <= 3'h0;
        repeat (6) @(posedge clk);
        #1 chk("held", {first_interrupt_out, second_interrupt_out}, 16'h0003);
        go(pmec_pkg::MODE_CODE_IDLE);
        chk("det exit", {first_interrupt_out, second_interrupt_out}, 16'h0000);
        // idle hides the latch, so re-enter detect to see it was cleared
        go(pmec_pkg::MODE_CODE_DETECT);
        chk("det reentry", {first_interrupt_out, second_interrupt_out}, 16'h0000);
        go(pmec_pkg::MODE_CODE_PARTIAL);
        chk("partial en", {adc_en, pm_en}, 16'h0001);
        chk("por count", por_n, 16'h0002);
        rd(pmec_pkg::ADDR_ENABLE0, 16'h0008);
        wr(pmec_pkg::ADDR_SAG_TH, 16'h0123);
        rd(pmec_pkg::ADDR_SAG_TH, 16'h0000);
        @(posedge clk) pm_done <= 1'b1;
        @(posedge clk) pm_done <= 1'b0;
        repeat (8) @(posedge clk);
        #1 chk("pm done", first_interrupt_out, 16'h0001);
        go(pmec_pkg::MODE_CODE_IDLE);
        idle_pins();
        go(pmec_pkg::MODE_CODE_NORMAL);
        rd(pmec_pkg::ADDR_SAG_TH, 16'h0c7b);
        conclude();
    end
endmodule : tb_power_mode_event_control
